// >>> hdl/psr_latch_bit.v
// Purpose: One latched status indication with clear-on-read behaviour.
// Assumes: A read pulse lasts one cycle; soft reset is synchronous.
// Notes: LATCH_LOW=1 holds a zero, LATCH_LOW=0 holds a one.
`timescale 1ns/1ps
module psr_latch_bit #(
    parameter LATCH_LOW = 0
) (
    // Clock and reset
    input wire core_clk,
    input wire rstn,
    input wire soft_rst,
    // Condition and read strobe
    input wire live,
    input wire rd_pulse,
    // Reported value
    output wire value
);
    reg held_r;
    wire event_now;
    wire held_nxt;

    assign event_now = LATCH_LOW ? ~live : live;
    // Set wins over the clear caused by a read in the same cycle.
    assign held_nxt = event_now ? 1'b1 : (rd_pulse ? 1'b0 : held_r);
    assign value = LATCH_LOW ? ~(held_r | event_now) & live : (held_r | live);

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            held_r <= LATCH_LOW ? 1'b1 : 1'b0;
        end else if (soft_rst) begin
            held_r <= LATCH_LOW ? 1'b1 : 1'b0;
        end else begin
            held_r <= held_nxt;
        end
    end
endmodule

// >>> hdl/psr_regs.v
// Purpose: PHY basic status and identifier registers with latched indications.
// Assumes: One-cycle read and write strobes from the management frame logic.
// Notes: Read data is registered and valid the cycle after the read strobe.
`timescale 1ns/1ps
`include "psr_consts.vh"
module psr_regs (
    // Clock and reset
    input wire core_clk,
    input wire rstn,
    // Register access
    input wire [`PSR_AW-1:0] reg_idx,
    input wire rd_stb,
    input wire wr_stb,
    input wire [`PSR_DW-1:0] wr_data,
    output reg [`PSR_DW-1:0] rd_data,
    output reg rd_valid,
    // Live conditions from the PHY core
    input wire an_complete,
    input wire remote_fault,
    input wire link_up,
    input wire jabber
);
    reg [`PSR_DW-1:0] id_high_r;
    reg [`PSR_DW-1:0] id_low_r;
    wire soft_rst;
    wire status_rd;
    wire fault_v;
    wire link_v;
    wire jabber_v;
    wire [`PSR_DW-1:0] status_word;
    reg [`PSR_DW-1:0] rd_nxt;

    function hit;
        input [`PSR_AW-1:0] idx;
        input [`PSR_AW-1:0] want;
        begin
            hit = (idx == want);
        end
    endfunction

    // Self-clearing: the strobe itself is the one-cycle reset pulse.
    assign soft_rst = wr_stb & hit(reg_idx, `PSR_IDX_CONTROL)
        & wr_data[`PSR_BIT_SOFT_RESET];
    assign status_rd = rd_stb & hit(reg_idx, `PSR_IDX_STATUS);

    psr_latch_bit #(.LATCH_LOW(0)) u_fault (
        .core_clk(core_clk), .rstn(rstn), .soft_rst(soft_rst),
        .live(remote_fault), .rd_pulse(status_rd), .value(fault_v)
    );
    psr_latch_bit #(.LATCH_LOW(1)) u_link (
        .core_clk(core_clk), .rstn(rstn), .soft_rst(soft_rst),
        .live(link_up), .rd_pulse(status_rd), .value(link_v)
    );
    psr_latch_bit #(.LATCH_LOW(0)) u_jabber (
        .core_clk(core_clk), .rstn(rstn), .soft_rst(soft_rst),
        .live(jabber), .rd_pulse(status_rd), .value(jabber_v)
    );

    // Fixed capability bits plus the negotiation, fault, link and jabber bits.
    assign status_word = `PSR_STATUS_FIXED
        | ({{(`PSR_DW-1){1'b0}}, an_complete} << `PSR_BIT_AN_DONE)
        | ({{(`PSR_DW-1){1'b0}}, fault_v} << `PSR_BIT_REMOTE_FAULT)
        | ({{(`PSR_DW-1){1'b0}}, link_v} << `PSR_BIT_LINK)
        | ({{(`PSR_DW-1){1'b0}}, jabber_v} << `PSR_BIT_JABBER);

    always @* begin
        rd_nxt = `PSR_ZERO16;
        if (hit(reg_idx, `PSR_IDX_STATUS)) begin
            rd_nxt = status_word;
        end else if (hit(reg_idx, `PSR_IDX_ID_HIGH)) begin
            rd_nxt = id_high_r;
        end else if (hit(reg_idx, `PSR_IDX_ID_LOW)) begin
            rd_nxt = id_low_r;
        end
    end

    // Status writes fall through with no effect.
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            id_high_r <= `PSR_ID_HIGH_DEFAULT;
            id_low_r <= `PSR_ID_LOW_DEFAULT;
            rd_data <= `PSR_ZERO16;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_stb;
            if (rd_stb) begin
                rd_data <= rd_nxt;
            end
            if (soft_rst) begin
                id_high_r <= `PSR_ID_HIGH_DEFAULT;
                id_low_r <= `PSR_ID_LOW_DEFAULT;
            end else if (wr_stb && hit(reg_idx, `PSR_IDX_ID_HIGH)) begin
                id_high_r <= wr_data;
            end else if (wr_stb && hit(reg_idx, `PSR_IDX_ID_LOW)) begin
                id_low_r <= wr_data;
            end
        end
    end
endmodule

// >>> pkg/psr_consts.vh
// Purpose: Named constants for the PHY status and identifier register bank.
// Assumes: 16-bit registers addressed by a 5-bit management register index.
// Notes: Identifier defaults are arbitrary neutral values.
`ifndef PSR_CONSTS_VH
`define PSR_CONSTS_VH

`define PSR_AW 5
`define PSR_DW 16
`define PSR_IDX_CONTROL 5'h00
`define PSR_IDX_STATUS 5'h01
`define PSR_IDX_ID_HIGH 5'h02
`define PSR_IDX_ID_LOW 5'h03
`define PSR_BIT_SOFT_RESET 15
`define PSR_BIT_AN_DONE 5
`define PSR_BIT_REMOTE_FAULT 4
`define PSR_BIT_LINK 2
`define PSR_BIT_JABBER 1
// Fixed capability bits: 14..11, 3 and 0 set; 15, 10..6 clear.
`define PSR_STATUS_FIXED 16'h7809
// Arbitrary neutral identifier defaults.
`define PSR_ID_HIGH_DEFAULT 16'h1234
`define PSR_ID_LOW_DEFAULT 16'h5670
`define PSR_ZERO16 16'h0000

`endif

// >>> testbench/psr_mgmt_model.sv
// Purpose: management station model. Assumes: fixed read latency. Notes: drives at negedge.
`timescale 1ns/1ps
module psr_mgmt_model (input wire core_clk, rd_valid, input wire [15:0] rd_data,
    output reg [4:0] reg_idx = 5'h1f, output reg rd_stb = 1'b0, wr_stb = 1'b0,
    output reg [15:0] wr_data = 16'h0);
    // Idle lines carry the inverse of the last value, so stale data cannot pass.
    task wr(input [4:0] i, input [15:0] d);
        @(negedge core_clk) {reg_idx, wr_data, wr_stb} = {i, d, 1'b1};
        @(negedge core_clk) {reg_idx, wr_data, wr_stb} = {~i, ~d, 1'b0};
    endtask
    task rd(input [4:0] i, output [15:0] q);
        @(negedge core_clk) {reg_idx, rd_stb} = {i, 1'b1};
        @(negedge core_clk) {reg_idx, rd_stb} = {~i, 1'b0};
        if (rd_valid !== 1'b1) psr_regs_bench.report_and_stop(1'b1);
        q = rd_data;
    endtask
endmodule

// >>> testbench/psr_regs_bench.sv
// Purpose: bench of psr_regs. Assumes: 125 MHz clock. Notes: table rows, then edge cases.
`timescale 1ns/1ps
module psr_regs_bench;
    reg core_clk = 1'b0, rstn = 1'b0;
    reg an_complete = 1'b0, remote_fault = 1'b0, link_up = 1'b0, jabber = 1'b0;
    wire [4:0] reg_idx;
    wire rd_stb, wr_stb, rd_valid;
    wire [15:0] wr_data, rd_data;
    reg [15:0] q;
    // Row: live flags in 24:21, index in 20:16, expected word in 15:0.
    reg [24:0] rows [0:7] = '{25'h0017809, 25'h1417829, 25'h1e1783f, 25'h141783f,
        25'h141782d, 25'h1421234, 25'h1435670, 25'h15f0000};
    integer n_errors = 0, comparisons = 0, i;
    always #4 core_clk = ~core_clk;
    psr_mgmt_model mgr (.*);
    psr_regs dut (.*);
    task rdchk(input [4:0] idx, input [15:0] exp);
        mgr.rd(idx, q);
        comparisons = comparisons + 1;
        n_errors = n_errors + (q !== exp);
        if (q !== exp) $display("Error at %0t: seen %h expected %h", $time, q, exp);
    endtask
    task report_and_stop(input hung);
        n_errors = n_errors + hung;
        if (n_errors == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge core_clk);
        rstn = 1'b1;
        for (i = 0; i < 8; i = i + 1) begin
            {an_complete, remote_fault, link_up, jabber} = rows[i][24:21];
            rdchk(rows[i][20:16], rows[i][15:0]);
        end
        {remote_fault, link_up} = 2'h2;
        @(negedge core_clk) {remote_fault, link_up} = 2'h1;
        mgr.wr(5'h01, 16'h0);
        rdchk(5'h01, 16'h7839);
        mgr.wr(5'h02, 16'hbeef);
        mgr.wr(5'h03, 16'h0a5c);
        rdchk(5'h02, 16'hbeef);
        rdchk(5'h03, 16'h0a5c);
        mgr.wr(5'h00, 16'h8000);
        rdchk(5'h02, 16'h1234);
        rdchk(5'h03, 16'h5670);
        rdchk(5'h01, 16'h7829);
        // Mid-run hardware reset: identifiers back to defaults, link reads dropped.
        mgr.wr(5'h02, 16'hbeef);
        @(negedge core_clk) rstn = 1'b0;
        repeat (2) @(negedge core_clk);
        rstn = 1'b1;
        rdchk(5'h02, 16'h1234);
        rdchk(5'h01, 16'h7829);
        rdchk(5'h01, 16'h782d);
        report_and_stop(1'b0);
    end
endmodule
bind psr_regs psr_regs_chk chk_i (.*);

// >>> testbench/psr_regs_chk.sv
// Purpose: port checks of psr_regs. Assumes: one-cycle strobes. Notes: bound by the bench.
`timescale 1ns/1ps
module psr_regs_chk (input wire core_clk, rstn, rd_stb, wr_stb, rd_valid, an_complete,
    remote_fault, link_up, jabber, input wire [4:0] reg_idx, input wire [15:0] wr_data, rd_data);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    wire st = rd_stb && reg_idx == 5'h01;
    a_read_answer: assert property (rd_stb |=> rd_valid) else $error("read not answered");
    a_caps_high: assert property (st |=> rd_data[15:9] == 7'h3c)
        else $error("bad ability bits");
    a_caps_low: assert property (st |=> (rd_data & 16'h1c9) == 16'h9)
        else $error("bad ability bits");
    a_an_live: assert property (st |=> rd_data[5] == $past(an_complete))
        else $error("bad negotiation bit");
    a_fault_seen: assert property (st && remote_fault |=> rd_data[4])
        else $error("fault bit clear");
    a_link_low: assert property (st && !link_up |=> !rd_data[2])
        else $error("link bit set");
    a_jabber_seen: assert property (st && jabber |=> rd_data[1])
        else $error("jabber bit clear");
    a_unmapped_zero: assert property (rd_stb && reg_idx > 5'h03 |=> rd_data == 16'h0)
        else $error("unmapped read not zero");
    c_fault: cover property (rd_valid && rd_data[4]);
    c_link: cover property (rd_valid && rd_data[2]);
    c_soft: cover property (wr_stb && reg_idx == 5'h00 && wr_data[15]);
endmodule
